//--- hdl/rra_arbiter.v
// Function
// [R1] with equal A or B selectors and staggered power-up, the first up becomes primary and the later one waits.
// [R2] with both selectors at Clear, neither controller takes a role and both stay nonconfigured.
// [R3] on a selector conflict the indicator of the own position blinks, primary blinks only on the first up; here it blinks whenever nxt_role is primary.
// [R4] with equal A or B selectors and simultaneous start, both controllers wait.
// [R5] the decision uses redundancy link, ring link, drops of both sides, online state, selector and run state.
// [R6] with a healthy redundancy link and equal start, one ends running primary and the other standby.
// [R7] when a tie must be broken the controller set to A is preferred for primary.
// [R8] when only one controller sees drops and both links are healthy, it becomes primary and the other waits.
// [R9] drops count as good while one is seen and as lost only after none is seen for 3 seconds.
// [R10] the ring-link input is the supplementary path over the drop ring, separate from the redundancy link.
// [R11] with the redundancy link down and ring link up, the one already primary or the A one runs primary.
// [R12] with both links down every controller ends as running primary.
// [R13] a running primary keeps its role; a starting partner becomes standby or, without redundancy link, waits.
// [R14] without conflict the selector decides only on simultaneous start, otherwise the first up is primary.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "rra_defines.vh"

module rra_arbiter #(
    parameter [31:0] DROP_LOSS_CYC = `RRA_DROP_LOSS_CYC,
    parameter [31:0] BLINK_CYC     = `RRA_BLINK_CYC
) (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // link and drop status pins from outside
    input  wire        redundancy_link_ok,
    input  wire        ring_link_ok,
    input  wire        remote_drop_seen,
    // counterpart state, asynchronous to us
    input  wire        peer_drops_ok,
    input  wire        peer_up,
    input  wire        peer_primary,
    input  wire        peer_online,
    input  wire [1:0]  peer_selector,
    // own selector switch
    input  wire [1:0]  selector,
    // role and indicators
    output reg  [2:0]  role,
    output reg         primary_role_indicator,
    output reg         standby_role_indicator,
    output reg         sel_a_indicator,
    output reg         sel_b_indicator
);

    // limitations: the partner role arrives as plain levels and is trusted as is;
    // a partner that flips its lines faster than the chain settles may be seen
    // in a mixed state for one cycle

    // every status line from the pins or the partner is asynchronous to pclk;
    // all of them share one two-stage chain so they age together, at the cost of
    // three cycles between a pin change and the role that follows from it
    // the low bit of the chain is a spare and stays zero
    // two-flop synchronisers for every pin input
    reg [11:0] sync1_ff;
    reg [11:0] sync2_ff;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_ff <= 12'h000;
            sync2_ff <= 12'h000;
        end
        else
        begin
            sync1_ff <= {redundancy_link_ok, ring_link_ok, remote_drop_seen, peer_drops_ok, peer_up,
                         peer_primary, peer_online, peer_selector, selector, 1'b0};
            sync2_ff <= sync1_ff;
        end
    end

    // synchronised views of the pins and of the partner
    wire       hsb_ok    = sync2_ff[11];
    wire       ring_ok   = sync2_ff[10];   // see [R10]
    wire       drop_raw  = sync2_ff[9];
    wire       p_drops   = sync2_ff[8];
    wire       p_up      = sync2_ff[7];
    wire       p_primary_role_indicator    = sync2_ff[6];
    wire       p_online  = sync2_ff[5];
    wire [1:0] p_sel     = sync2_ff[4:3];
    wire [1:0] own_sel   = sync2_ff[2:1];

    // a single missed drop must not hand the primary role away, so a drop that
    // disappears is only declared lost after the full quiet interval; any drop
    // seen again restarts the interval and marks the drops good at once
    // the counter stops at the limit instead of wrapping
    // the limit is a parameter so a bench can shorten the three seconds
    // drop loss filter: good at once, lost only after a full quiet interval
    reg [31:0] quiet_ff;
    reg        drops_ok_ff;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            quiet_ff    <= 32'h00000000;
            drops_ok_ff <= 1'b0;
        end
        else if (drop_raw)
        begin
            quiet_ff    <= 32'h00000000;
            drops_ok_ff <= 1'b1;                       // see [R9]
        end
        else if (quiet_ff >= DROP_LOSS_CYC - 32'h1)
            drops_ok_ff <= 1'b0;                       // see [R9]
        else
            quiet_ff <= quiet_ff + 32'h1;
    end

    // register map
    //   ctrl   : bit 0 start request, bit 1 run, bit 2 online
    //   status : bits 2:0 role, 4:3 partner selector, 6:5 own selector,
    //            bit 7 partner up, bit 8 ring link, bit 9 redundancy link,
    //            bit 10 drops good; read only
    // any other offset answers with an error, reads zero and drops writes
    // read data is taken from the setup cycle, so it stands with ready
    // no wait state; writes land at the access edge with ready
    // software control: start request, run/stop and online state
    reg [2:0] ctrl_ff;
    wire apb_wr = psel & penable & pwrite & pready;
    wire apb_rd = psel & ~penable & ~pwrite;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= `RRA_CTRL_RESET;
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            // no wait state: ready rises in the first access cycle
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr != `RRA_REG_CTRL) & (paddr != `RRA_REG_STATUS);
            if (apb_wr && paddr == `RRA_REG_CTRL)
                ctrl_ff <= pwdata[2:0];
            if (apb_rd)
            begin
                if (paddr == `RRA_REG_CTRL)
                    prdata <= {29'h0, ctrl_ff};
                else if (paddr == `RRA_REG_STATUS)
                    prdata <= {21'h0, drops_ok_ff, hsb_ok, ring_ok, p_up, own_sel, p_sel, role};
                else
                    prdata <= 32'h00000000;
            end
        end
    end

    wire start_req = ctrl_ff[`RRA_CTRL_START_BIT];
    wire run_req   = ctrl_ff[`RRA_CTRL_RUN_BIT];
    wire online    = ctrl_ff[`RRA_CTRL_ONL_BIT];

    // selector decode shared by the role and lamp logic
    function sel_is;
        input [1:0] pos;
        input [1:0] want;
        begin
            sel_is = (pos == want);
        end
    endfunction

    // the order of power-up is reduced to one question asked once per start:
    // was the partner already up when our start bit rose; a partner that rises
    // in the same cycle counts as already up
    // the answer is kept until the start bit falls, so a partner that drops
    // and returns later does not change who came first

    // first-up detection: the partner was already up when we asked to start
    reg peer_first_ff;
    reg started_ff;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            peer_first_ff <= 1'b0;
            started_ff    <= 1'b0;
        end
        else if (!start_req)
            started_ff <= 1'b0;
        else if (!started_ff)
        begin
            started_ff    <= 1'b1;
            peer_first_ff <= p_up;                     // see [R14]
        end
    end

    // the two controllers conflict whenever they share a selector position
    wire own_a    = sel_is(own_sel, `RRA_SEL_A);
    wire conflict = (own_sel == p_sel);
    wire i_first  = ~peer_first_ff & ~p_up;          // partner still down at our decision

    // priority of the decision, highest first:
    //   no start or Clear selector -> nonconfigured
    //   already primary            -> stay primary
    //   stopped or offline         -> wait
    //   both links lost            -> primary, each side for itself
    //   same selector as partner   -> first up leads, otherwise wait
    //   partner already primary    -> standby with link, wait without
    //   partner absent             -> primary
    //   redundancy link lost       -> A side leads, the other waits
    //   drops on one side, ring up -> that side leads
    //   otherwise                  -> A side primary, B side standby
    // keeping primary sticky avoids two primaries driving the outputs
    // role decision, evaluated while starting; a running primary holds
    reg [2:0] nxt_role;
    always @*
    begin
        nxt_role = role;
        if (!start_req)
            nxt_role = `RRA_ROLE_NONCONF;
        else if (own_sel == `RRA_SEL_CLEAR)
            nxt_role = `RRA_ROLE_NONCONF;              // see [R2]
        else if (role == `RRA_ROLE_PRIMARY)
            nxt_role = `RRA_ROLE_PRIMARY;              // see [R13]
        else if (!run_req || !online)
            nxt_role = `RRA_ROLE_WAIT;                 // see [R5]
        else if (!hsb_ok && !ring_ok)
            nxt_role = `RRA_ROLE_PRIMARY;              // see [R12]
        else if (conflict)
        begin
            // simultaneous start both wait, otherwise first up leads
            if (i_first && !p_up)
                nxt_role = `RRA_ROLE_PRIMARY;          // see [R1]
            else
                nxt_role = `RRA_ROLE_WAIT;             // see [R1] see [R4]
        end
        else if (p_primary_role_indicator)
            nxt_role = hsb_ok ? `RRA_ROLE_STANDBY : `RRA_ROLE_WAIT;   // see [R13]
        else if (!p_up || !p_online)
            nxt_role = `RRA_ROLE_PRIMARY;              // see [R14]
        else if (!hsb_ok)
            nxt_role = own_a ? `RRA_ROLE_PRIMARY : `RRA_ROLE_WAIT;    // see [R11] see [R7]
        else if (ring_ok && drops_ok_ff != p_drops)
            nxt_role = drops_ok_ff ? `RRA_ROLE_PRIMARY : `RRA_ROLE_WAIT; // see [R8]
        else
            nxt_role = own_a ? `RRA_ROLE_PRIMARY : `RRA_ROLE_STANDBY; // see [R6] see [R7]
    end

    // half period of the conflict blink; all lamps share it so they blink in step
    // a parameter so a bench can shorten it
    // blink timebase for conflict indication
    reg [31:0] blink_cnt_ff;
    reg        blink_ff;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            blink_cnt_ff <= 32'h00000000;
            blink_ff     <= 1'b0;
        end
        else if (blink_cnt_ff >= BLINK_CYC - 32'h1)
        begin
            blink_cnt_ff <= 32'h00000000;
            blink_ff     <= ~blink_ff;
        end
        else
            blink_cnt_ff <= blink_cnt_ff + 32'h1;
    end

    // lamps follow the next role so they change in the same cycle as role;
    // standby never lights during a conflict, there is no standby then
    // in a conflict Clear blinks both position lamps; outside a conflict Clear lights neither
    // role register and indicators, all straight from flops
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            role                   <= `RRA_ROLE_NONCONF;
            primary_role_indicator <= 1'b0;
            standby_role_indicator <= 1'b0;
            sel_a_indicator        <= 1'b0;
            sel_b_indicator        <= 1'b0;
        end
        else
        begin
            role <= nxt_role;
            if (conflict)
            begin
                // clear blinks both position lamps; primary blinks whenever the next role is primary
                sel_a_indicator        <= blink_ff & (own_sel != `RRA_SEL_B);     // see [R3]
                sel_b_indicator        <= blink_ff & (own_sel != `RRA_SEL_A);     // see [R3]
                primary_role_indicator <= blink_ff & (nxt_role == `RRA_ROLE_PRIMARY); // see [R3]
                standby_role_indicator <= 1'b0;                                    // see [R3]
            end
            else
            begin
                sel_a_indicator        <= sel_is(own_sel, `RRA_SEL_A);
                sel_b_indicator        <= sel_is(own_sel, `RRA_SEL_B);
                primary_role_indicator <= (nxt_role == `RRA_ROLE_PRIMARY);
                standby_role_indicator <= (nxt_role == `RRA_ROLE_STANDBY);
            end
        end
    end

endmodule // rra_arbiter

//--- hdl/rra_defines.vh
`ifndef RRA_DEFINES_VH
`define RRA_DEFINES_VH

// selector positions
`define RRA_SEL_CLEAR      2'h0
`define RRA_SEL_A          2'h1
`define RRA_SEL_B          2'h2

// role codes
`define RRA_ROLE_NONCONF   3'h0
`define RRA_ROLE_STARTING  3'h1
`define RRA_ROLE_WAIT      3'h2
`define RRA_ROLE_STANDBY   3'h3
`define RRA_ROLE_PRIMARY   3'h4

// apb register offsets
`define RRA_REG_CTRL       12'h000
`define RRA_REG_STATUS     12'h004

// ctrl field positions
`define RRA_CTRL_START_BIT 0
`define RRA_CTRL_RUN_BIT   1
`define RRA_CTRL_ONL_BIT   2
`define RRA_CTRL_RESET     3'h0

// timing
`define RRA_CLK_MHZ        100
`define RRA_DROP_LOSS_MS   3000
`define RRA_DROP_LOSS_CYC  (`RRA_DROP_LOSS_MS * 1000 * `RRA_CLK_MHZ)
`define RRA_BLINK_CYC      25000000

`endif

//--- tb/rra_arb_sva.sv
`timescale 1ns/10ps
`include "rra_defines.vh"
module rra_arb_sva (
    // bus side
    input logic        pclk, presetn, psel, penable, pready, pslverr,
    input logic [11:0] paddr,
    // role side
    input logic        redundancy_link_ok, ring_link_ok,
    input logic [1:0]  selector, peer_selector,
    input logic [2:0]  role,
    input logic        primary_role_indicator, standby_role_indicator, sel_a_indicator, sel_b_indicator
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pairings; inputs pass a synchroniser, so the selector pairings need five steady cycles and the link-down case six
    wire cc = (selector == `RRA_SEL_CLEAR) && (peer_selector == `RRA_SEL_CLEAR);
    wire aa = (selector == `RRA_SEL_A) && (peer_selector == `RRA_SEL_A);
    wire bb = (selector == `RRA_SEL_B) && (peer_selector == `RRA_SEL_B);
    wire dn = !redundancy_link_ok && !ring_link_ok && (selector != peer_selector);
    property p_wait; psel && !penable |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("no ready after setup");
    property p_unmap; psel && penable && pready && (paddr[11:3] != 9'h0) |-> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    property p_cc_role; cc[*5] |-> role == `RRA_ROLE_NONCONF; endproperty
    a_cc_role: assert property (p_cc_role) else $error("clear took a role");
    property p_cc_ind; cc[*5] |-> !primary_role_indicator && !standby_role_indicator; endproperty
    a_cc_ind: assert property (p_cc_ind) else $error("clear lit a role light");
    property p_aa_ind; aa[*5] |-> !sel_b_indicator && !standby_role_indicator; endproperty
    a_aa_ind: assert property (p_aa_ind) else $error("a conflict lights");
    property p_bb_ind; bb[*5] |-> !sel_a_indicator && !standby_role_indicator; endproperty
    a_bb_ind: assert property (p_bb_ind) else $error("b conflict lights");
    property p_dn; dn[*6] |-> role != `RRA_ROLE_WAIT && role != `RRA_ROLE_STANDBY; endproperty
    a_dn: assert property (p_dn) else $error("links down but not primary");
    property p_sb; $rose(role == `RRA_ROLE_STANDBY) |-> redundancy_link_ok; endproperty
    a_sb: assert property (p_sb) else $error("standby without link");
    c_pri: cover property (role == `RRA_ROLE_PRIMARY);
    c_sb: cover property (role == `RRA_ROLE_STANDBY);
    c_wt: cover property (role == `RRA_ROLE_WAIT);
endmodule // rra_arb_sva

//--- tb/rra_peer.sv
`timescale 1ns/10ps
module rra_peer (
    // bench commands
    input  logic pclk, go, lead, drops,
    // counterpart status lines, one edge behind
    output logic peer_up, peer_primary, peer_online, peer_drops_ok
);
    // a counterpart that is down claims no role and no drops
    always @(posedge pclk)
    begin
        peer_up       <= go;
        peer_online   <= go;
        peer_primary  <= go & lead;
        peer_drops_ok <= go & drops;
    end
endmodule // rra_peer

//--- tb/redundant_role_arbiter_tb.sv
`timescale 1ns/10ps
`include "rra_defines.vh"
module redundant_role_arbiter_tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0;
    logic        red = 1'b1, ring = 1'b1, drop = 1'b1, go = 1'b0, lead = 1'b0, pdrop = 1'b1;
    logic        pready, pslverr, err, p_up, p_pri, p_onl, p_drop, pri_i, sb_i, a_i, b_i;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0]  sel = 2'h0, psl = 2'h0;
    logic [2:0]  role, acc_or = 3'h0, acc_and = 3'h7;
    int          bad_count = 0, checks = 0, cyc = 0;
    // short counts keep the drop-loss and blink waits small
    rra_arbiter #(.DROP_LOSS_CYC(32'h14), .BLINK_CYC(32'h4)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .redundancy_link_ok(red), .ring_link_ok(ring),
        .remote_drop_seen(drop), .peer_drops_ok(p_drop), .peer_up(p_up), .peer_primary(p_pri),
        .peer_online(p_onl), .peer_selector(psl), .selector(sel), .role(role), .primary_role_indicator(pri_i),
        .standby_role_indicator(sb_i), .sel_a_indicator(a_i), .sel_b_indicator(b_i));
    rra_peer i_peer (.pclk(pclk), .go(go), .lead(lead), .drops(pdrop), .peer_up(p_up),
        .peer_primary(p_pri), .peer_online(p_onl), .peer_drops_ok(p_drop));
    always #5 pclk = ~pclk;
    // light history {primary, a, b}: blinking shows as seen on and seen off
    always @(posedge pclk)
    begin
        acc_or  <= clr ? 3'h0 : acc_or | {pri_i, a_i, b_i};
        acc_and <= clr ? 3'h7 : acc_and & {pri_i, a_i, b_i};
        cyc     <= cyc + 1;
        if (cyc == 6000)
        begin
            bad_count++;
            results();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one bus transfer; waits for ready however long it takes
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    // f = {red, ring, own drop, peer drop, order}: order 0 joint, 1 peer first, 2 own first
    task run(input logic [1:0] s, ps, input logic [5:0] f, input logic [2:0] r, input logic [3:0] m);
        logic [3:0] li;
        li = {r == `RRA_ROLE_PRIMARY, r == `RRA_ROLE_STANDBY, s == `RRA_SEL_A, s == `RRA_SEL_B};
        apb(1'b1, `RRA_REG_CTRL, 32'h0);
        {go, lead, sel, psl, red, ring, drop, pdrop} <= {1'b0, f[1:0] == 2'h1, s, ps, f[5:2]};
        repeat (40) @(posedge pclk);
        go <= (f[1:0] != 2'h2);
        repeat (f[1:0] == 2'h1 ? 10 : 0) @(posedge pclk);
        apb(1'b1, `RRA_REG_CTRL, 32'h7);
        repeat (10) @(posedge pclk);
        go <= 1'b1;
        repeat (12) @(posedge pclk);
        chk(role, r);
        apb(1'b0, `RRA_REG_STATUS, 32'h0);
        chk(rd[2:0], r);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (16) @(posedge pclk);
        if (m[3])
            chk({acc_or, acc_and}, {m[2:0], 3'h0});
        else
            chk({pri_i, sb_i, a_i, b_i}, li);
    endtask
    task results;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `RRA_REG_CTRL, 32'h0);
        chk(rd, `RRA_CTRL_RESET);
        apb(1'b1, 12'h008, 32'hFFFFFFFF);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        run(2'h0, 2'h0, 6'h3C, `RRA_ROLE_NONCONF, 4'hB);
        run(2'h1, 2'h1, 6'h3D, `RRA_ROLE_WAIT, 4'hA);
        run(2'h1, 2'h1, 6'h3E, `RRA_ROLE_PRIMARY, 4'hE);
        run(2'h2, 2'h2, 6'h3C, `RRA_ROLE_WAIT, 4'h9);
        run(2'h1, 2'h2, 6'h3C, `RRA_ROLE_PRIMARY, 4'h0);
        run(2'h2, 2'h1, 6'h3C, `RRA_ROLE_STANDBY, 4'h0);
        run(2'h1, 2'h2, 6'h34, `RRA_ROLE_WAIT, 4'h0);
        run(2'h2, 2'h1, 6'h1C, `RRA_ROLE_WAIT, 4'h0);
        run(2'h2, 2'h1, 6'h01, `RRA_ROLE_PRIMARY, 4'h0);
        run(2'h2, 2'h1, 6'h3D, `RRA_ROLE_STANDBY, 4'h0);
        run(2'h2, 2'h1, 6'h3E, `RRA_ROLE_PRIMARY, 4'h0);
        results();
    end
endmodule // redundant_role_arbiter_tb
bind rra_arbiter rra_arb_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .paddr(paddr), .redundancy_link_ok(redundancy_link_ok),
    .ring_link_ok(ring_link_ok), .selector(selector), .peer_selector(peer_selector), .role(role),
    .primary_role_indicator(primary_role_indicator), .standby_role_indicator(standby_role_indicator),
    .sel_a_indicator(sel_a_indicator), .sel_b_indicator(sel_b_indicator));
